// *** rtl/ppm_pkg.sv ***
// ppm_pkg: shared constants and types for the peripheral pin multiplexer.
// assumes a 16-bit register port clocked by clk_sys; pad and peripheral
// signals are flat vectors indexed by the pin and function numbers below.
package ppm_pkg;

	// ==========================================================
	// sizes
	localparam int PPM_NPIN = 40;
	localparam int PPM_NFUNC = 115;
	typedef logic [6:0] ppm_func_t;

	// ==========================================================
	// register offsets on the plain port
	localparam logic [15:0] PPM_OFF_BUS_SEL = 16'h1C00;
	localparam logic [15:0] PPM_OFF_STATUS = 16'h1C01;
	localparam logic [15:0] PPM_OFF_SER_PD = 16'h1C17;
	localparam logic [15:0] PPM_OFF_HD_PD = 16'h1C19;
	localparam logic [15:0] PPM_OFF_BE_PD = 16'h1C4F;
	localparam logic [15:0] PPM_OFF_CTL_PD = 16'h1C50;

	// ==========================================================
	// bus selection fields and reset values
	localparam int PPM_PP_LSB = 12;
	localparam int PPM_SP1_LSB = 10;
	localparam int PPM_SP0_LSB = 8;
	localparam int PPM_CLKSEL_BIT = 15;
	localparam logic [15:0] PPM_BUS_SEL_MASK = 16'hFF00;
	localparam logic [15:0] PPM_BUS_SEL_RST = 16'h1000;
	localparam logic [15:0] PPM_PD_RST = 16'h0000;

	// mode codes
	localparam logic [2:0] PPM_PP_HOST = 3'h0;
	localparam logic [2:0] PPM_PP_SPI_UART = 3'h1;
	localparam logic [2:0] PPM_PP_GPIO = 3'h2;
	localparam logic [2:0] PPM_PP_SPI_SND3 = 3'h3;
	localparam logic [2:0] PPM_PP_SND2_UART = 3'h4;
	localparam logic [2:0] PPM_PP_SPI4_UART = 3'h5;
	localparam logic [2:0] PPM_PP_SPI_SND23 = 3'h6;
	localparam logic [2:0] PPM_PP_RSVD = 3'h7;
	localparam logic [1:0] PPM_SP_CARD = 2'h0;
	localparam logic [1:0] PPM_SP_ALT = 2'h1;
	localparam logic [1:0] PPM_SP_GPIO = 2'h2;
	localparam logic [1:0] PPM_SP_BSP = 2'h3;

	// ==========================================================
	// function index bases into periph_out / periph_oe / periph_in
	localparam int PPM_F_HOST = 0;
	localparam int PPM_F_SPI = 28;
	localparam int PPM_F_GP = 35;
	localparam int PPM_F_UART = 67;
	localparam int PPM_F_SND2 = 71;
	localparam int PPM_F_SND3 = 75;
	localparam int PPM_F_SND0 = 79;
	localparam int PPM_F_EXTERNAL_MEMORY_INTERFACE = 83;
	localparam int PPM_F_CARD1 = 90;
	localparam int PPM_F_CARD0 = 96;
	localparam int PPM_F_MULTICHANNEL_SPI_PORT = 102;
	localparam int PPM_F_BSP = 108;
	localparam int PPM_F_NONE = 127;

	// pin index bases
	localparam int PPM_PIN_HD = 1;
	localparam int PPM_PIN_CTL = 17;
	localparam int PPM_PIN_EM = 21;
	localparam int PPM_PIN_SP1 = 28;
	localparam int PPM_PIN_SP0 = 34;

	// idle level seen by a peripheral input with no pin; uart receive idles high
	localparam logic [114:0] PPM_IN_IDLE = 115'h1 << (PPM_F_UART + 2);

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} ppm_bus_s;

	typedef struct packed {
		logic [39:0] out;
		logic [39:0] oe;
	} ppm_pad_s;

endpackage : ppm_pkg

// *** rtl/ppm_pin_mux.sv ***
// ppm_pin_mux: routes shared pads to on-chip peripherals from one bus selection register.
// assumes peripherals present flat out/oe vectors, pads are resolved outside,
// and software resets affected peripherals itself after changing a mode field.
//
// Behaviour
// - all pin selections come from bus selection register
// - parallel field three bits, resets to 001
// - code 000 gives pins to host port
// - code 001: spi, gpio 12-17, sound2, uart
// - code 010: gpio 18-20,27-31 on data 8-15
// - code 011: spi on data 8-11, sound3 above
// - code 100: sound2 on 8-11, uart 12-15
// - code 101: spi on 8-11, uart 12-15
// - code 110: spi, gpio, sound2, sound3
// - interrupt pin carries host port in 000, spi clock in 001 and 110, else reserved
// - codes other than 000 and 111 put memory signals on control pins
// - second serial field resets 00, card port
// - second serial code 01 gives multichannel spi
// - second serial code 10 gives gpio 6-11
// - second serial pulldown bits 8 to 13
// - first serial field resets 00, card port
// - first serial code 01: sound0 plus gpio
// - first serial code 10: gpio 0-5
// - first serial code 11: buffered serial port
// - bit 15 picks shared buffered clock function
// - first serial pulldown bits 0 to 5
// - host data and control pulldown bit map
//
// Local design decision: the address-and-strobe port.
module ppm_pin_mux (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// register port
	input wire ppm_pkg::ppm_bus_s bus_req,
	output logic [15:0] bus_rdata,
	// peripheral side
	input wire logic [ppm_pkg::PPM_NFUNC-1:0] periph_out,
	input wire logic [ppm_pkg::PPM_NFUNC-1:0] periph_oe,
	output logic [ppm_pkg::PPM_NFUNC-1:0] periph_in,
	// pad side
	input wire logic [ppm_pkg::PPM_NPIN-1:0] pad_in,
	output ppm_pkg::ppm_pad_s pad_drive,
	output logic [ppm_pkg::PPM_NPIN-1:0] pad_pulldown_inhibit
);
	import ppm_pkg::*;

	// ==========================================================
	// pin function table
	// returns the function index a pin carries in the given modes
	function automatic ppm_func_t pin_func(input int p, input logic [2:0] pp,
		input logic [1:0] sp1, input logic [1:0] sp0, input logic clksel);
		int f;
		int d;
		int k;
		f = PPM_F_NONE;
		d = p - PPM_PIN_HD;
		k = d % 4;
		if (p == 0)
		begin
			if (pp == PPM_PP_HOST)
				f = PPM_F_HOST;
			else if (pp == PPM_PP_SPI_UART || pp == PPM_PP_SPI_SND23)
				f = PPM_F_SPI;
		end
		else if (p < PPM_PIN_CTL)
		begin
			if (pp == PPM_PP_HOST)
				f = PPM_F_HOST + p;
			else if (d < 8)
			begin
				// low data pins carry spi data and gpio 12-17 only in 001 and 110
				if (pp == PPM_PP_SPI_UART || pp == PPM_PP_SPI_SND23)
					f = (d < 2) ? PPM_F_SPI + 1 + d : PPM_F_GP + 10 + d;
			end
			else if (d < 12)
			begin
				case (pp)
					PPM_PP_SPI_UART, PPM_PP_SND2_UART, PPM_PP_SPI_SND23:
						f = PPM_F_SND2 + k;
					PPM_PP_GPIO:
						f = PPM_F_GP + ((k < 3) ? 18 + k : 27);
					PPM_PP_SPI_SND3, PPM_PP_SPI4_UART:
						f = PPM_F_SPI + ((k == 0) ? 0 : (k == 1) ? 3 : k - 1);
					default:
						f = PPM_F_NONE;
				endcase
			end
			else
			begin
				case (pp)
					PPM_PP_SPI_UART, PPM_PP_SND2_UART, PPM_PP_SPI4_UART:
						f = PPM_F_UART + k;
					PPM_PP_GPIO:
						f = PPM_F_GP + 28 + k;
					PPM_PP_SPI_SND3, PPM_PP_SPI_SND23:
						f = PPM_F_SND3 + k;
					default:
						f = PPM_F_NONE;
				endcase
			end
		end
		else if (p < PPM_PIN_EM)
		begin
			if (pp == PPM_PP_HOST)
				f = PPM_F_HOST + p;
			else if (pp == PPM_PP_SPI_UART || pp == PPM_PP_SPI_SND23)
				f = PPM_F_SPI + 3 + p - PPM_PIN_CTL;
		end
		else if (p < PPM_PIN_SP1)
		begin
			if (pp == PPM_PP_HOST)
				f = PPM_F_HOST + p;
			else if (pp != PPM_PP_RSVD)
				f = PPM_F_EXTERNAL_MEMORY_INTERFACE + p - PPM_PIN_EM;
		end
		else if (p < PPM_PIN_SP0)
		begin
			case (sp1)
				PPM_SP_CARD: f = PPM_F_CARD1 + p - PPM_PIN_SP1;
				PPM_SP_ALT: f = PPM_F_MULTICHANNEL_SPI_PORT + p - PPM_PIN_SP1;
				PPM_SP_GPIO: f = PPM_F_GP + 6 + p - PPM_PIN_SP1;
				default: f = PPM_F_NONE;
			endcase
		end
		else
		begin
			d = p - PPM_PIN_SP0;
			case (sp0)
				PPM_SP_CARD: f = PPM_F_CARD0 + d;
				PPM_SP_ALT: f = (d < 4) ? PPM_F_SND0 + d : PPM_F_GP + d;
				PPM_SP_GPIO: f = PPM_F_GP + d;
				default:
				begin
					// last pin: clksel low = receive clock, high = source clock
					if (d < 5)
						f = PPM_F_BSP + d;
					else
						f = PPM_F_BSP + (clksel ? 6 : 5);
				end
			endcase
		end
		return ppm_func_t'(f);
	endfunction : pin_func

	// ==========================================================
	// registers
	logic [15:0] bus_sel_reg;
	logic [15:0] ser_pd_reg;
	logic [15:0] hd_pd_reg;
	logic [15:0] be_pd_reg;
	logic [15:0] ctl_pd_reg;
	logic [15:0] rdata_reg;
	ppm_pad_s pad_reg;
	logic [PPM_NFUNC-1:0] periph_in_reg;
	logic [PPM_NPIN-1:0] pd_reg;

	// mode fields, the only source of every selection
	wire [2:0] pp_mode = bus_sel_reg[PPM_PP_LSB +: 3];
	wire [1:0] sp1_mode = bus_sel_reg[PPM_SP1_LSB +: 2];
	wire [1:0] sp0_mode = bus_sel_reg[PPM_SP0_LSB +: 2];
	wire clk_sel = bus_sel_reg[PPM_CLKSEL_BIT];

	// address decode
	wire hit_bus_sel = bus_req.addr == PPM_OFF_BUS_SEL;
	wire hit_status = bus_req.addr == PPM_OFF_STATUS;
	wire hit_ser_pd = bus_req.addr == PPM_OFF_SER_PD;
	wire hit_hd_pd = bus_req.addr == PPM_OFF_HD_PD;
	wire hit_be_pd = bus_req.addr == PPM_OFF_BE_PD;
	wire hit_ctl_pd = bus_req.addr == PPM_OFF_CTL_PD;

	// status shows which fields hold an undefined code
	wire [15:0] status_word = {14'h0000, sp1_mode == PPM_SP_BSP, pp_mode == PPM_PP_RSVD};

	// read mux; unmapped addresses read as zero
	wire [15:0] rdata_sel =
		hit_bus_sel ? bus_sel_reg :
		hit_status ? status_word :
		hit_ser_pd ? ser_pd_reg :
		hit_hd_pd ? hd_pd_reg :
		hit_be_pd ? be_pd_reg :
		hit_ctl_pd ? ctl_pd_reg : 16'h0000;
	wire [15:0] rdata_next = bus_req.rd ? rdata_sel : 16'h0000;

	// next values for software registers
	wire [15:0] bus_sel_next = (bus_req.wr && hit_bus_sel) ?
		(bus_req.wdata & PPM_BUS_SEL_MASK) : bus_sel_reg;
	wire [15:0] ser_pd_next = (bus_req.wr && hit_ser_pd) ? bus_req.wdata : ser_pd_reg;
	wire [15:0] hd_pd_next = (bus_req.wr && hit_hd_pd) ? bus_req.wdata : hd_pd_reg;
	wire [15:0] be_pd_next = (bus_req.wr && hit_be_pd) ? bus_req.wdata : be_pd_reg;
	wire [15:0] ctl_pd_next = (bus_req.wr && hit_ctl_pd) ? bus_req.wdata : ctl_pd_reg;

	// register file; undefined bus selection bits are not stored
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			bus_sel_reg <= PPM_BUS_SEL_RST;
			ser_pd_reg <= PPM_PD_RST;
			hd_pd_reg <= PPM_PD_RST;
			be_pd_reg <= PPM_PD_RST;
			ctl_pd_reg <= PPM_PD_RST;
			rdata_reg <= 16'h0000;
		end
		else
		begin
			bus_sel_reg <= bus_sel_next;
			ser_pd_reg <= ser_pd_next;
			hd_pd_reg <= hd_pd_next;
			be_pd_reg <= be_pd_next;
			ctl_pd_reg <= ctl_pd_next;
			rdata_reg <= rdata_next;
		end
	end

	// ==========================================================
	// per pin selection
	ppm_func_t pin_sel [PPM_NPIN];
	logic [PPM_NPIN-1:0] pin_live;
	ppm_pad_s pad_next;

	// a reserved pin has no function: it drives nothing, enable held low
	genvar gp;
	generate
		for (gp = 0; gp < PPM_NPIN; gp++)
		begin : g_pin
			assign pin_sel[gp] = pin_func(gp, pp_mode, sp1_mode, sp0_mode, clk_sel);
			assign pin_live[gp] = pin_sel[gp] != ppm_func_t'(PPM_F_NONE);
			assign pad_next.out[gp] = pin_live[gp] & periph_out[pin_sel[gp]];
			assign pad_next.oe[gp] = pin_live[gp] & periph_oe[pin_sel[gp]];
		end
	endgenerate

	// input steering: only the selected function sees its pad, others idle
	logic [PPM_NFUNC-1:0] periph_in_next;
	always_comb
	begin
		periph_in_next = PPM_IN_IDLE;
		for (int p = 0; p < PPM_NPIN; p++)
		begin
			if (pin_live[p])
				periph_in_next[pin_sel[p]] = pad_in[p];
		end
	end

	// pulldown inhibit per pin; shared vector so each pad sees its own bit
	logic [PPM_NPIN-1:0] pd_next;
	always_comb
	begin
		pd_next = '0;
		pd_next[0] = ctl_pd_reg[12];
		for (int n = 0; n < 16; n++)
			pd_next[PPM_PIN_HD + n] = hd_pd_reg[n];
		for (int n = 0; n < 4; n++)
			pd_next[PPM_PIN_CTL + n] = ctl_pd_reg[8 + n];
		pd_next[PPM_PIN_EM] = be_pd_reg[7];
		pd_next[PPM_PIN_EM + 1] = be_pd_reg[8];
		pd_next[PPM_PIN_EM + 2] = ctl_pd_reg[3];
		pd_next[PPM_PIN_EM + 3] = ctl_pd_reg[2];
		pd_next[PPM_PIN_EM + 4] = ctl_pd_reg[4];
		pd_next[PPM_PIN_EM + 5] = ctl_pd_reg[5];
		pd_next[PPM_PIN_EM + 6] = ctl_pd_reg[1];
		for (int n = 0; n < 6; n++)
		begin
			pd_next[PPM_PIN_SP1 + n] = ser_pd_reg[n + 8];
			pd_next[PPM_PIN_SP0 + n] = ser_pd_reg[n];
		end
	end

	// output flops; costs one cycle of latency through the mux, but the
	// pads never see glitches from the select decode
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pad_reg <= '0;
			periph_in_reg <= PPM_IN_IDLE;
			pd_reg <= '0;
		end
		else
		begin
			pad_reg <= pad_next;
			periph_in_reg <= periph_in_next;
			pd_reg <= pd_next;
		end
	end

	assign bus_rdata = rdata_reg;
	assign pad_drive = pad_reg;
	assign periph_in = periph_in_reg;
	assign pad_pulldown_inhibit = pd_reg;

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_field_write_lands: assert property (
		bus_req.wr && hit_bus_sel |=> pp_mode == $past(bus_req.wdata[14:12])
			&& sp0_mode == $past(bus_req.wdata[9:8]))
		else $error("bus selection write not stored");

	a_host_data_out: assert property (
		pp_mode == PPM_PP_HOST |=> pad_drive.out[9] == $past(periph_out[PPM_F_HOST + 9])
			&& pad_drive.oe[9] == $past(periph_oe[PPM_F_HOST + 9]))
		else $error("host data pin not driven by host port");

	a_uart_rx_steer: assert property (
		pp_mode == PPM_PP_SPI_UART |=> periph_in[PPM_F_UART + 2] == $past(pad_in[15]))
		else $error("uart receive not taken from data pin 14");

	a_gpio_high_out: assert property (
		pp_mode == PPM_PP_GPIO |=> pad_drive.out[9] == $past(periph_out[PPM_F_GP + 18])
			&& pad_drive.out[12] == $past(periph_out[PPM_F_GP + 27]))
		else $error("gpio not on high data pins");

	a_spi_clk_alt: assert property (
		pp_mode == PPM_PP_SPI_SND3 |=> periph_in[PPM_F_SPI] == $past(pad_in[9]))
		else $error("spi clock not taken from data pin 8");

	a_irq_pin_quiet: assert property (
		pp_mode inside {[3'h2:3'h5]} |=> !pad_drive.oe[0] && !pad_drive.oe[17])
		else $error("reserved pin driven");

	a_memory_ctrl_pins: assert property (
		pp_mode != PPM_PP_HOST && pp_mode != PPM_PP_RSVD
			|=> pad_drive.oe[21] == $past(periph_oe[PPM_F_EXTERNAL_MEMORY_INTERFACE]))
		else $error("memory byte mask not routed");

	a_sp1_gpio_out: assert property (
		sp1_mode == PPM_SP_GPIO |=> pad_drive.out[31] == $past(periph_out[PPM_F_GP + 9]))
		else $error("second serial pin 3 not gpio 9");

	a_bsp_shared_clk: assert property (
		sp0_mode == PPM_SP_BSP && clk_sel |=> periph_in[PPM_F_BSP + 6] == $past(pad_in[39])
			&& periph_in[PPM_F_BSP + 5] == PPM_IN_IDLE[PPM_F_BSP + 5])
		else $error("shared clock pin not on source clock");

	a_sp1_pulldown: assert property (
		bus_req.wr && hit_ser_pd ##1 1'b1 |=> pad_pulldown_inhibit[28] == $past(bus_req.wdata[8], 2))
		else $error("second serial pulldown bit misplaced");

	a_card1_route: assert property (
		sp1_mode == PPM_SP_CARD |=> pad_drive.out[28] == $past(periph_out[PPM_F_CARD1]))
		else $error("second serial pin 0 not card clock");

	a_multichannel_spi_port_route: assert property (
		sp1_mode == PPM_SP_ALT |=> pad_drive.out[31] == $past(periph_out[PPM_F_MULTICHANNEL_SPI_PORT + 3]))
		else $error("second serial pin 3 not spi controller in");

	a_sp1_reserved: assert property (
		sp1_mode == PPM_SP_BSP |=> pad_drive.oe[PPM_PIN_SP1 +: 6] == 6'h00)
		else $error("undefined second serial code drives a pin");

	a_sound3_route: assert property (
		pp_mode == PPM_PP_SPI_SND23 |=> pad_drive.out[13] == $past(periph_out[PPM_F_SND3]))
		else $error("data pin 12 not third sound clock");

	a_card0_route: assert property (
		sp0_mode == PPM_SP_CARD |=> pad_drive.oe[36] == $past(periph_oe[PPM_F_CARD0 + 2]))
		else $error("first serial pin 2 not card data 0");

	a_sound0_route: assert property (
		sp0_mode == PPM_SP_ALT |=> pad_drive.out[36] == $past(periph_out[PPM_F_SND0 + 2]))
		else $error("first serial pin 2 not first sound transmit");

	a_bsp_rx_clock: assert property (
		sp0_mode == PPM_SP_BSP && !clk_sel
			|=> pad_drive.out[39] == $past(periph_out[PPM_F_BSP + 5]))
		else $error("shared clock pin not on receive clock");

	c_host_mode: cover property (pp_mode == PPM_PP_HOST ##1 pad_drive.oe[1]);
	c_bsp_mode: cover property (sp0_mode == PPM_SP_BSP && clk_sel);
	c_status_read: cover property (bus_req.rd && hit_status ##1 bus_rdata != 16'h0000);
	c_multichannel_spi_port_mode: cover property (sp1_mode == PPM_SP_ALT ##1 pad_drive.oe[28]);
	c_gpio_mode: cover property (pp_mode == PPM_PP_GPIO ##1 pad_drive.oe[9]);

endmodule : ppm_pin_mux

// *** verif/ppm_far_side.sv ***
// ppm_far_side: stand-in for the peripherals and board pins around the mux.
// assumes the bench exercises one function and one pin at a time.
module ppm_far_side (
	// bench selection
	input wire ppm_pkg::ppm_func_t sel_func,
	input wire logic [5:0] sel_pin,
	input wire logic drive,
	// mux facing
	input wire ppm_pkg::ppm_pad_s pad_drive,
	output logic [ppm_pkg::PPM_NFUNC-1:0] periph_out,
	output logic [ppm_pkg::PPM_NFUNC-1:0] periph_oe,
	output logic [ppm_pkg::PPM_NPIN-1:0] pad_in
);
	import ppm_pkg::*;

	// ============================================================
	// peripherals: one function drives high; index out of range drives none
	// stateless, so nothing is left to restart after a mode change
	wire logic [PPM_NFUNC-1:0] one_hot = PPM_NFUNC'(1) << sel_func;
	assign periph_out = drive ? one_hot : '0;
	assign periph_oe = drive ? one_hot : '0;

	// ============================================================
	// board: chosen pin shows the non-idle level, others sit at pulldown 0
	wire logic ext_lvl = (sel_func < PPM_NFUNC) ? ~PPM_IN_IDLE[sel_func] : 1'b1;
	always_comb
	begin
		for (int p = 0; p < PPM_NPIN; p++)
			pad_in[p] = pad_drive.oe[p] ? pad_drive.out[p] : (p == int'(sel_pin)) & ext_lvl;
	end
endmodule : ppm_far_side

// *** verif/tb_top.sv ***
// tb_top: self-checking bench for the peripheral pin multiplexer.
// assumes the register map and function indices of ppm_pkg.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ppm_pkg::*;

	// ============================================================
	// signals and instances
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	ppm_bus_s bus_req = '0;
	logic [15:0] bus_rdata;
	logic [PPM_NFUNC-1:0] periph_out, periph_oe, periph_in;
	logic [PPM_NPIN-1:0] pad_in, pad_pulldown_inhibit;
	ppm_pad_s pad_drive;
	ppm_func_t sel_func = 7'h7F;
	logic [5:0] sel_pin = '0;
	logic drive = 1'b0;
	logic [15:0] rd_val;
	int err_count = 0;
	int comparisons = 0;

	// free-running 100 MHz clock
	always #5 clk_sys = ~clk_sys;

	ppm_pin_mux ppm_pin_mux_inst (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .periph_out(periph_out), .periph_oe(periph_oe),
		.periph_in(periph_in), .pad_in(pad_in), .pad_drive(pad_drive),
		.pad_pulldown_inhibit(pad_pulldown_inhibit));
	ppm_far_side ppm_far_side_inst (.sel_func(sel_func), .sel_pin(sel_pin), .drive(drive),
		.pad_drive(pad_drive), .periph_out(periph_out), .periph_oe(periph_oe),
		.pad_in(pad_in));

	// ============================================================
	// reporting and compares
	task automatic report_and_stop();
		if (err_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	task automatic note(input logic ok, input string what);
		comparisons++;
		if (ok !== 1'b1)
		begin
			err_count++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask : note

	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		note(got === exp, what);
	endtask : cmp_word

	task automatic cmp_pins(input logic [39:0] got, input logic [39:0] exp, input string what);
		note(got === exp, what);
	endtask : cmp_pins

	task automatic cmp_bit(input logic got, input logic exp, input string what);
		note(got === exp, what);
	endtask : cmp_bit

	// ============================================================
	// register port master: one-cycle strobes, read data the cycle after
	task automatic bus_write(input logic [15:0] addr, input logic [15:0] data);
		@(posedge clk_sys);
		bus_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
	endtask : bus_write

	task automatic bus_read(input logic [15:0] addr, output logic [15:0] data);
		@(posedge clk_sys);
		bus_req <= '{addr: addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		#1 data = bus_rdata;
	endtask : bus_read

	// drive one function out, then listen on the pin; 127 means reserved pin
	task automatic check_route(input int pin, input int f);
		@(posedge clk_sys);
		sel_pin <= 6'(pin);
		sel_func <= 7'(f);
		drive <= 1'b1;
		@(posedge clk_sys);
		#1 cmp_bit(pad_drive.oe[pin], f != 127, "pin enable");
		cmp_bit(pad_drive.out[pin], f != 127, "pin value");
		@(posedge clk_sys);
		drive <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 cmp_bit(pad_drive.oe[pin], 1'b0, "pin released");
		if (f != 127)
			cmp_bit(periph_in[f], ~PPM_IN_IDLE[f], "steered input");
	endtask : check_route

	// ============================================================
	// scenarios
	task automatic test_reset_values();
		bus_read(PPM_OFF_BUS_SEL, rd_val);
		cmp_word(rd_val, 16'h1000, "mode reset");
		@(posedge clk_sys);
		#1 cmp_word(bus_rdata, 16'h0000, "read data one cycle");
		bus_read(16'h1C02, rd_val);
		cmp_word(rd_val, 16'h0000, "unmapped read");
		check_route(0, 28);
		check_route(36, 98);
	endtask : test_reset_values

	// every mode code of all three fields; pins probed per code below
	task automatic test_modes();
		int pins [8] = '{0, 9, 13, 21, 28, 31, 36, 39};
		int fn [8][8] = '{
			'{0, 9, 13, 21, 90, 93, 98, 101},
			'{28, 71, 67, 83, 102, 105, 81, 40},
			'{127, 53, 63, 83, 41, 44, 37, 40},
			'{127, 28, 75, 83, 127, 127, 110, 113},
			'{127, 71, 67, 83, 90, 93, 98, 101},
			'{127, 28, 67, 83, 102, 105, 81, 40},
			'{28, 71, 75, 83, 41, 44, 37, 40},
			'{127, 127, 127, 127, 127, 127, 110, 114}};
		logic [2:0] c;
		logic [15:0] v;
		for (int i = 0; i < 8; i++)
		begin
			c = 3'(i);
			v = {c == 3'h7, c, c[1:0], c[1:0], 8'h00};
			bus_write(PPM_OFF_BUS_SEL, v ^ 16'h00A5);
			bus_read(PPM_OFF_BUS_SEL, rd_val);
			cmp_word(rd_val, v, "mode readback");
			bus_read(PPM_OFF_STATUS, rd_val);
			cmp_word(rd_val, {14'h0000, c[1:0] == 2'h3, c == 3'h7}, "status");
			for (int k = 0; k < 8; k++)
				check_route(pins[k], fn[i][k]);
		end
	endtask : test_modes

	function automatic logic [39:0] pd_map(logic [15:0] s, logic [15:0] h, logic [15:0] b,
		logic [15:0] c);
		return {s[5:0], s[13:8], c[1], c[5], c[4], c[2], c[3], b[8], b[7], c[11:8], h, c[12]};
	endfunction : pd_map

	// pulldown map, readback, then a reset in mid-run
	task automatic test_pulldown();
		logic [15:0] offs [4] = '{PPM_OFF_SER_PD, PPM_OFF_HD_PD, PPM_OFF_BE_PD, PPM_OFF_CTL_PD};
		logic [15:0] vals [4] = '{16'h2916, 16'hA5C3, 16'h0180, 16'h1F3E};
		for (int i = 0; i < 4; i++)
			bus_write(offs[i], vals[i]);
		for (int i = 0; i < 4; i++)
		begin
			bus_read(offs[i], rd_val);
			cmp_word(rd_val, vals[i], "pulldown readback");
		end
		cmp_pins(pad_pulldown_inhibit, pd_map(vals[0], vals[1], vals[2], vals[3]), "pd map");
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		#1 cmp_pins(pad_pulldown_inhibit, '0, "pd after reset");
		cmp_pins(pad_drive.oe, '0, "pads quiet after reset");
		bus_read(PPM_OFF_BUS_SEL, rd_val);
		cmp_word(rd_val, 16'h1000, "mode after reset");
	endtask : test_pulldown

	// ============================================================
	// main sequence and hang guard
	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		test_reset_values();
		test_modes();
		test_pulldown();
		report_and_stop();
	end

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		report_and_stop();
	end
endmodule : tb_top
